//--- common/bus_xchg_pkg.sv
package bus_xchg_pkg;

  // Bus-cycle status codes, driven on the three status lines
  localparam logic [2:0] ST_CODE    = 3'h4;
  localparam logic [2:0] ST_MEMRD   = 3'h5;
  localparam logic [2:0] ST_MEMWR   = 3'h6;
  localparam logic [2:0] ST_PASSIVE = 3'h7;

  // Idle clocks required after each exchange
  localparam int IDLE_GAP = 1;
  // Clocks within which an idle-bus request must see a release or cycle start
  localparam int IDLE_START_MAX = 3;

  // Kind of cycle the core asks for
  typedef enum logic [1:0]
  {
    CYC_CODE  = 2'h0,
    CYC_READ  = 2'h1,
    CYC_WRITE = 2'h2
  } cyc_kind_t;

  // Core's cycle request and its qualifiers
  typedef struct packed
  {
    logic      valid;
    cyc_kind_t kind;
    logic      lowByte;
    logic      firstIntAck;
    logic      locked;
  } cyc_req_t;

  // Two-way pin drive side as two signals: output and enable
  typedef struct packed
  {
    logic o;
    logic oe;
  } pin_drv_t;

endpackage

//--- rtl/rqgt_pulse_detect.sv
`timescale 1ns/1ps
// Flags a one-clock low pulse on the shared request/grant line
module rqgt_pulse_detect
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Line level and qualifier
  input  wire logic lineIn,
  input  wire logic listen,
  // Falling edge seen while listening
  output logic      pulseSeen
);
  logic prevLine_r;

  // Previous level; idle line reads high through bus hold
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      prevLine_r <= 1'b1;
    else
      prevLine_r <= lineIn;
  end

  // Active-low pulse starts at the falling edge
  assign pulseSeen = listen && prevLine_r && !lineIn;
endmodule

//--- rtl/local_bus_request_grant.sv
`timescale 1ns/1ps
// What this block does
// - Status returns to passive 111 in T3 and stays passive through any wait states.
// - During the grant sequence the status outputs float, weakly held at one.
// - The device grants with a one-clock low pulse in T4 or Ti; float begins next clock.
// - During the grant sequence the bus interface drives nothing on the local bus.
// - Every handover is exactly three pulses: request, grant, release.
// - All pulses are active low, with one idle clock after each exchange.
// - Memory cycle yields in T4 if asked by T2 and not low byte, first int ack or locked.
// - A request on an idle bus is granted next clock or a cycle starts within three.
module local_bus_request_grant
  import bus_xchg_pkg::*;
(
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  // Core cycle request
  input  wire bus_xchg_pkg::cyc_req_t  cycReq,
  output logic                         cycTaken,
  output logic                         cycDone,
  // Memory ready
  input  wire logic                    ready,
  // Status lines, three-signal form
  output logic [2:0]                   busStatusO,
  output logic                         busStatusOe,
  output logic                         busStatusKeep,
  // Request/grant line, three-signal form
  input  wire logic                    requestGrantLineI,
  output logic                         requestGrantLineO,
  output logic                         requestGrantLineOe,
  // Local bus drive permission and grant state
  output logic                         busDriveEn,
  output logic                         granted
);
  import bus_xchg_pkg::*;

  // Bus states plus the grant sequence
  // Ti is the idle state; Tw repeats until ready is seen
  typedef enum logic [6:0]
  {
    S_TI    = 7'h01,
    S_T1    = 7'h02,
    S_T2    = 7'h04,
    S_T3    = 7'h08,
    S_TW    = 7'h10,
    S_T4    = 7'h20,
    S_GRANT = 7'h40
  } bus_state_t;

  bus_state_t state_r;
  bus_state_t state_nxt;
  cyc_req_t   cur_r;
  logic [2:0] status_r;
  logic       reqPend_r;
  logic       reqOk_r;
  logic       reqPulse;
  logic       relPulse;
  logic       canRelease;
  logic       doGrant;
  logic       cycStart;
  logic       pulseSeen;

  // Quiet-clock counter width; a spare bit keeps it legal for a zero gap
  localparam int GAP_W = $clog2(IDLE_GAP + 1) + 1;
  logic [GAP_W-1:0] idleCnt_r;

  // Status code for a cycle kind
  // Unused encoding falls back to passive so no bus cycle is signalled
  function automatic logic [2:0] kind_code(input cyc_kind_t k);
    unique case (k)
      CYC_CODE:  kind_code = ST_CODE;
      CYC_READ:  kind_code = ST_MEMRD;
      CYC_WRITE: kind_code = ST_MEMWR;
      default:   kind_code = ST_PASSIVE;
    endcase
  endfunction

  // Qualifiers that let a memory cycle give up the bus at its T4
  function automatic logic release_ok(input cyc_req_t c, input logic early);
    release_ok = early && !c.lowByte && !c.firstIntAck && !c.locked;
  endfunction

  // One detector: requests outside grant, releases inside it
  // Own grant drive and the quiet clock are masked, never taken as requests
  rqgt_pulse_detect rqgt_pulse_detect_inst
  (
    .mclk      (mclk),
    .rstn      (rstn),
    .lineIn    (requestGrantLineI),
    .listen    (!doGrant && (idleCnt_r == '0)),
    .pulseSeen (pulseSeen)
  );
  assign reqPulse = pulseSeen && (state_r != S_GRANT) && !reqPend_r;
  assign relPulse = pulseSeen && (state_r == S_GRANT);

  // Release allowed only on a qualifying cycle
  // Low byte, first acknowledge and lock all pin the bus to this master
  assign canRelease = release_ok(cur_r, reqOk_r);

  // A new cycle starts when T1 comes next
  assign cycStart = (state_nxt == S_T1) && (state_r != S_T1);

  // Grant in T4 of a qualifying cycle, or on an idle bus
  // Built from registered state and the core request only, so the line drive has no loop
  always_comb
  begin
    doGrant = 1'b0;
    if (reqPend_r)
    begin
      if (state_r == S_T4 && canRelease)
        doGrant = 1'b1;
      else if (state_r == S_TI && !cycReq.valid)
        doGrant = 1'b1;
      else if ((state_r == S_T4 || state_r == S_TI) && !cycReq.valid && canRelease)
        doGrant = 1'b1;
    end
  end

  // Next bus state
  // Grant state is entered the clock after the grant pulse, never with it
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      S_TI:    state_nxt = doGrant ? S_GRANT : (cycReq.valid ? S_T1 : S_TI);
      S_T1:    state_nxt = S_T2;
      S_T2:    state_nxt = S_T3;
      S_T3:    state_nxt = ready ? S_T4 : S_TW;
      S_TW:    state_nxt = ready ? S_T4 : S_TW;
      S_T4:    state_nxt = doGrant ? S_GRANT : (cycReq.valid ? S_T1 : S_TI);
      S_GRANT: state_nxt = relPulse ? (cycReq.valid ? S_T1 : S_TI) : S_GRANT;
      default: state_nxt = S_TI;
    endcase
  end

  // Bus state register
  // Synchronous reset; a bus cycle in flight is simply dropped
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      state_r <= S_TI;
    else
      state_r <= state_nxt;
  end

  // Latch the cycle being run
  // Qualifiers are held here since the core drops its request after T1
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      cur_r <= '0;
    else if (cycStart)
      cur_r <= cycReq;
  end

  // Pending request and whether it came by T2; idle requests count as early
  // A late request is carried into a cycle that starts straight from T4, which then counts it as early
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      reqPend_r <= 1'b0;
      reqOk_r   <= 1'b0;
    end
    else if (doGrant)
    begin
      reqPend_r <= 1'b0;
      reqOk_r   <= 1'b0;
    end
    else if (reqPulse)
    begin
      reqPend_r <= 1'b1;
      reqOk_r   <= state_r inside {S_TI, S_T1, S_T2, S_T4};
    end
    else if (state_r == S_T4 && !canRelease)
      reqOk_r   <= reqPend_r && (state_nxt == S_T1);
  end

  // Quiet clocks left after an exchange; the line is ignored until it runs out
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      idleCnt_r <= '0;
    else if (relPulse)
      idleCnt_r <= GAP_W'(IDLE_GAP);
    else if (idleCnt_r != '0)
      idleCnt_r <= idleCnt_r - GAP_W'(1);
  end

  // Status code, passive from T3 entry on and outside cycles
  // Registered so the status lines never glitch between codes
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      status_r <= ST_PASSIVE;
    else if (cycStart)
      status_r <= kind_code(cycReq.kind);
    else if (state_nxt == S_T3 || (state_r == S_TW && ready) || state_nxt == S_GRANT)
      status_r <= ST_PASSIVE;
  end

  // Three pulses only: grant is the device's single drive on the line
  // Combinational so the pulse falls in the T4 or idle clock itself
  assign requestGrantLineO  = 1'b0;
  assign requestGrantLineOe = doGrant;

  // Float status in grant; keeper holds it at one
  // Keeper stands in for the pin's bus hold, so nothing else pulls the lines
  assign busStatusO    = status_r;
  assign busStatusOe   = (state_r != S_GRANT);
  assign busStatusKeep = (state_r == S_GRANT);
  assign busDriveEn    = (state_r != S_GRANT);
  assign granted       = (state_r == S_GRANT);

  // Core handshake
  // cycTaken is combinational; the core holds its request until it is seen
  assign cycTaken = cycStart;
  assign cycDone  = (state_r == S_T4);
endmodule

//--- dv/local_bus_request_grant_assertions.sv
`timescale 1ns/1ps
// Watches the grant exchange at the top ports
module local_bus_request_grant_assertions
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rstn,
  // Status lines
  input wire logic [2:0] busStatusO,
  input wire logic       busStatusOe,
  input wire logic       busStatusKeep,
  // Request/grant line and grant state
  input wire logic       requestGrantLineI,
  input wire logic       requestGrantLineO,
  input wire logic       requestGrantLineOe,
  input wire logic       busDriveEn,
  input wire logic       granted
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Grant pulse ends after one clock and the hold begins
  sequence enterGrant;
    ##1 (!requestGrantLineOe && granted);
  endsequence
  grant_pulse_a: assert property ($rose(requestGrantLineOe) |-> enterGrant)
    else $error("grant pulse malformed");
  grant_float_a: assert property (granted |-> !busStatusOe && busStatusKeep)
    else $error("status driven in grant");
  grant_nodrive_a: assert property (granted |-> !busDriveEn)
    else $error("bus driven in grant");
  pulse_low_a: assert property (requestGrantLineOe |-> !requestGrantLineO)
    else $error("grant pulse not low");
  release_back_a: assert property (granted && !requestGrantLineI |=> !granted && busStatusOe)
    else $error("bus not reclaimed");
  grant_cause_a: assert property ($rose(granted) |-> $past(requestGrantLineOe))
    else $error("hold without grant pulse");
  grant_once_a: assert property (requestGrantLineOe |-> !granted)
    else $error("second grant in hold");
  status_code_a: assert property (busStatusOe |-> busStatusO[2])
    else $error("status code outside set");
endmodule
bind local_bus_request_grant local_bus_request_grant_assertions
  local_bus_request_grant_assertions_inst (.mclk(mclk), .rstn(rstn),
  .busStatusO(busStatusO), .busStatusOe(busStatusOe), .busStatusKeep(busStatusKeep),
  .requestGrantLineI(requestGrantLineI), .requestGrantLineO(requestGrantLineO),
  .requestGrantLineOe(requestGrantLineOe), .busDriveEn(busDriveEn), .granted(granted));

//--- dv/rqgt_master_model.sv
`timescale 1ns/1ps
// Other local bus master on the shared line
module rqgt_master_model
(
  // Clock
  input  wire logic mclk,
  // Device grant drive
  input  wire logic devOe,
  // High pulls the shared line low
  output logic      mLow
);
  initial mLow = 1'h0;
  // One clock low, then back to the pull-up
  task automatic pulse();
    @(posedge mclk) mLow <= 1'h1;
    @(posedge mclk) mLow <= 1'h0;
  endtask
  // Clocks until the grant pulse shows; bounded
  task automatic waitGrant(output int n);
    for (n = 1; n < 10; n++)
      @(posedge mclk) if (devOe === 1'h1) break;
  endtask
endmodule

//--- dv/local_bus_request_grant_test.sv
`timescale 1ns/1ps
module local_bus_request_grant_test;
  import bus_xchg_pkg::*;
  logic       mclk, rstn, ready, mLow, cycTaken, cycDone, stOe, stKeep;
  logic       rgO, rgOe, driveEn, granted;
  logic [2:0] stO;
  cyc_req_t   cycReq;
  int         errors = 0, totalChecks = 0, cyc = 0;
  // Wire level: low if anyone pulls, else pull-up
  wire line = ~((rgOe & ~rgO) | mLow);
  local_bus_request_grant local_bus_request_grant_inst (.mclk(mclk), .rstn(rstn),
    .cycReq(cycReq), .cycTaken(cycTaken), .cycDone(cycDone), .ready(ready),
    .busStatusO(stO), .busStatusOe(stOe), .busStatusKeep(stKeep),
    .requestGrantLineI(line), .requestGrantLineO(rgO), .requestGrantLineOe(rgOe),
    .busDriveEn(driveEn), .granted(granted));
  rqgt_master_model rqgt_master_model_inst (.mclk(mclk), .devOe(rgOe), .mLow(mLow));
  // Clock
  initial
  begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the few dozen clocks needed
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      errors++;
      end_of_test();
    end
  end
  // Request, grant, release on an idle bus
  task automatic t_idle_grant();
    int n;
    rqgt_master_model_inst.pulse();
    rqgt_master_model_inst.waitGrant(n);
    chk(3'(n), 3'h1);
    #1;
    chk({stKeep, stOe, driveEn}, 3'h4);
    chk(3'(granted), 3'h1);
    rqgt_master_model_inst.pulse();
    #1;
    chk({granted, stOe, stKeep}, 3'h2);
    $display("t_idle_grant done");
  endtask
  // Each cycle kind, with a wait state on the read
  task automatic t_cycles();
    logic [2:0] codes [3];
    codes = '{ST_CODE, ST_MEMRD, ST_MEMWR};
    @(posedge mclk);
    for (int k = 0; k < 3; k++)
    begin
      cycReq <= '{1'h1, cyc_kind_t'(k), 1'h0, 1'h0, 1'h0};
      repeat (20) @(posedge mclk) if (cycTaken === 1'h1) break;
      cycReq.valid <= 1'h0;
      ready <= 1'(k != 1);
      repeat (6) @(posedge mclk) if (stO === codes[k]) break;
      chk(stO, codes[k]);
      if (k == 1)
      begin
        repeat (3) @(posedge mclk);
        chk(stO, ST_PASSIVE);
      end
      ready <= 1'h1;
      repeat (20) @(posedge mclk) if (cycDone === 1'h1) break;
      chk(stO, ST_PASSIVE);
    end
    $display("t_cycles done");
  endtask
  // Request in T2 of a read: grant in its T4, or after it for a low byte
  task automatic t_mem_grant(input logic lowB);
    int n;
    @(posedge mclk);
    cycReq <= '{1'h1, CYC_READ, lowB, 1'h0, 1'h0};
    repeat (20) @(posedge mclk) if (cycTaken === 1'h1) break;
    cycReq.valid <= 1'h0;
    rqgt_master_model_inst.pulse();
    rqgt_master_model_inst.waitGrant(n);
    chk(3'(n), lowB ? 3'h3 : 3'h2);
    chk(3'(cycDone), 3'(!lowB));
    #1;
    chk({granted, stOe, driveEn}, 3'h4);
    rqgt_master_model_inst.pulse();
    #1;
    chk({granted, stOe, stKeep}, 3'h2);
    $display("t_mem_grant done");
  endtask
  // Reset, then the scenarios
  initial
  begin
    rstn = 1'h0;
    ready = 1'h1;
    cycReq = '0;
    repeat (3) @(posedge mclk);
    chk({stO[0], stOe, rgOe}, 3'h6);
    rstn <= 1'h1;
    t_idle_grant();
    t_cycles();
    t_mem_grant(1'h0);
    t_mem_grant(1'h1);
    end_of_test();
  end
endmodule
